// ---- scl_line_config.v ----
// Line configuration bank of a four-channel serial controller, with the clock
// routing, handshake pins and transceiver mode decode that it steers.
// Assumes all pin and clock levels are synchronous to clk and far slower.
// Clock paths are sampled levels, so every routed clock lags its source by one
// clk cycle; the x4 multiplier itself sits outside this block.
// Reserved source codes give a quiet level (high where that receive or transmit clock is inverted) rather than a stray clock.
// Contract
// - Shallow bit limits transmit FIFO to four
// - Direct mode: request-to-send follows forced bit
// - Bit order bit puts first bit at seven
// - Terminal ready bit exists on channel three
// - Carrier pin drives value when direction set
// - Hold bit keeps clock multiplier in reset
// - Quad bit selects multiplied generator input clock
// - Receive clock invert moves sampling to rising
// - Transmit clock invert moves launch to falling
// - Receive clock source select, code three reserved
// - Transmit clock source select including divide-sixteen
// - Generator source select from oscillators or pins
// - Transmit clock replaces request-to-send when enabled
// - Transceiver field resets to all high impedance
// - Transceiver codes map to signalling standards
// - Carrier transition sets sticky change flag
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "scl_line_config_regs.vh"
module scl_line_config (
	input wire clk,
	input wire rst_b,
	input wire [11:0] regAddr,
	input wire [31:0] regWrData,
	input wire regWr,
	input wire regRd,
	output wire [31:0] regRdData,
	input wire osc1Clk,
	input wire osc2Clk,
	input wire osc3Clk,
	input wire [3:0] rxClkPin,
	input wire [3:0] txClkPin,
	input wire [3:0] baudGenOut,
	input wire [3:0] pllRxClk,
	input wire [3:0] pllTxClk,
	input wire [3:0] multOutClk,
	input wire [3:0] coreRts,
	input wire [3:0] forcedRtsBit,
	input wire [3:0] carrierPinIn,
	output wire [3:0] multInClk,
	output wire [3:0] multiplierHold,
	output wire [3:0] baudGenIn,
	output wire [3:0] rxCoreClk,
	output wire [3:0] txCoreClk,
	output wire [3:0] rtsPin,
	output wire [3:0] carrierPinOut,
	output wire [3:0] carrierPinOe_b,
	output wire [19:0] txFifoLimit,
	output wire [3:0] rxBitOrderMsb,
	output wire [7:0] dataLineStd,
	output wire [7:0] hsLineStd,
	output wire terminalReadyCh3
);
	reg [31:0] lineCfg_q [0:3];
	reg [31:0] rdData_q;
	wire [3:0] carrierLevel;
	wire [3:0] carrierFlag;
	wire [3:0] flagClr;
	wire statHit;
	reg [3:0] chHit;
	integer i;
	integer j;
	integer k;

	// Byte address of each channel's configuration word
	// (the four words sit 0x80 apart, but an explicit table keeps them exact)
	function [11:0] chOffset;
		input [1:0] ch;
		begin
			case (ch)
				2'h0: chOffset = `SCL_OFF_CH0;
				2'h1: chOffset = `SCL_OFF_CH1;
				2'h2: chOffset = `SCL_OFF_CH2;
				default: chOffset = `SCL_OFF_CH3;
			endcase
		end
	endfunction

	// Writable bits; terminal ready only lives in the channel 3 word
	// and upper reserved bits never store in any word
	function [31:0] chMask;
		input [1:0] ch;
		begin
			if (ch == 2'h3) begin
				chMask = `SCL_WMASK_CH3;
			end else begin
				chMask = `SCL_WMASK_CHX;
			end
		end
	endfunction

	assign statHit = (regAddr == `SCL_OFF_STAT);
	assign flagClr = (regWr && statHit) ? regWrData[`SCL_F_STFLG] : 4'h0;

	// One-hot channel decode shared by the write and the read path, so that
	// a word can never store under one address and read back under another;
	// unmapped addresses give no hit and are ignored
	always @* begin
		chHit = 4'h0;
		for (j = 0; j < 4; j = j + 1) begin
			chHit[j] = (regAddr == chOffset(j[1:0]));
		end
	end

	// Configuration words; reserved upper bits never store
	// A write lands at the edge that samples the strobe
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			for (i = 0; i < 4; i = i + 1) begin
				lineCfg_q[i] <= `SCL_RST_VAL;
			end
		end else if (regWr) begin
			for (i = 0; i < 4; i = i + 1) begin
				if (chHit[i]) begin
					lineCfg_q[i] <= regWrData & chMask(i[1:0]);
				end
			end
		end
	end

	// Read data stands for exactly the cycle after the strobe
	// and returns to zero, so unmapped reads also give zero
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rdData_q <= 32'h0000_0000;
		end else begin
			rdData_q <= 32'h0000_0000;
			if (regRd) begin
				for (k = 0; k < 4; k = k + 1) begin
					if (chHit[k]) begin
						rdData_q <= lineCfg_q[k];
					end
				end
				if (statHit) begin
					rdData_q <= {24'h00_0000, carrierFlag, carrierLevel};
				end
			end
		end
	end

	assign regRdData = rdData_q;
	assign terminalReadyCh3 = lineCfg_q[3][`SCL_B_DTR];

	// Per-channel slice: clock routing, handshake pins and line standards.
	// Every slice reads only its own word, so channels never disturb each
	// other when software rewrites one of them
	genvar c;
	generate
		for (c = 0; c < 4; c = c + 1) begin : gCh
			wire [31:0] cfg;
			wire [1:0] rxSel;
			wire [2:0] txSel;
			wire [2:0] genSel;
			wire [2:0] xcvr;
			wire div16Clk;
			reg genSrc;
			reg rxSrc;
			reg txSrc;
			wire genClk;
			wire txClkNow;
			reg rtsNext;
			reg [1:0] dataStdNext;
			reg [1:0] hsStdNext;
			reg multIn_q;
			reg genIn_q;
			reg rxClk_q;
			reg txClk_q;
			reg rts_q;
			reg carrier_out_value_q;
			reg cdOe_b_q;
			reg [4:0] fifoLim_q;
			reg [1:0] dataStd_q;
			reg [1:0] hsStd_q;

			assign cfg = lineCfg_q[c];
			assign rxSel = cfg[`SCL_F_RCS];
			assign txSel = cfg[`SCL_F_TCS];
			assign genSel = cfg[`SCL_F_BCS];
			assign xcvr = cfg[`SCL_F_XCVR];

			// Generator source; reserved codes give a quiet clock
			// This level also feeds the external multiplier input
			always @* begin
				case (genSel)
					`SCL_BCS_OSC1: genSrc = osc1Clk;
					`SCL_BCS_OSC2: genSrc = osc2Clk;
					`SCL_BCS_OSC3: genSrc = osc3Clk;
					`SCL_BCS_RXPIN: genSrc = rxClkPin[c];
					`SCL_BCS_TXPIN: genSrc = txClkPin[c];
					default: genSrc = 1'b0;
				endcase
			end

			// Multiplied clock replaces the generator source whenever the quad bit is set, hold or not
			assign genClk = cfg[`SCL_B_X4] ? multOutClk[c] : genSrc;

			// Divided generator output for the slowest transmit clock choice;
			// it runs all the time so a switch to it needs no warm-up
			scl_div16 uDiv (
				.clk(clk),
				.rst_b(rst_b),
				.src(baudGenOut[c]),
				.divOut(div16Clk)
			);

			// Receive clock source; code three is reserved and idle
			// Inversion is applied at the register below
			always @* begin
				case (rxSel)
					`SCL_RCS_BRG: rxSrc = baudGenOut[c];
					`SCL_RCS_PIN: rxSrc = rxClkPin[c];
					`SCL_RCS_DIGITAL_PLL: rxSrc = pllRxClk[c];
					default: rxSrc = 1'b0;
				endcase
			end

			// Transmit clock source; the transmit pin must be an input
			// while it is chosen, which software has to keep so
			always @* begin
				case (txSel)
					`SCL_TCS_BRG: txSrc = baudGenOut[c];
					`SCL_TCS_RXPIN: txSrc = rxClkPin[c];
					`SCL_TCS_TXPIN: txSrc = txClkPin[c];
					`SCL_TCS_DIGITAL_PLL: txSrc = pllTxClk[c];
					`SCL_TCS_DIV16: txSrc = div16Clk;
					default: txSrc = 1'b0;
				endcase
			end

			// Inverted transmit clock makes the core launch on the pin's falling edge
			assign txClkNow = txSrc ^ cfg[`SCL_B_TXINV];

			// Pin clock output wins, then direct mode, then the core's own control
			// Direct mode needs no transmit clock, so it works with clocks stopped
			always @* begin
				if (cfg[`SCL_B_TX_CLK_ON_RTS_PIN]) begin
					rtsNext = txClkNow;
				end else if (cfg[`SCL_B_DIRRTS]) begin
					rtsNext = forcedRtsBit[c];
				end else begin
					rtsNext = coreRts[c];
				end
			end

			// Signalling standard of data and clock lines, and of handshake lines
			// Only the split code gives different standards to the two groups
			always @* begin
				case (xcvr)
					`SCL_XCVR_V35: begin
						dataStdNext = `SCL_STD_V35;
						hsStdNext = `SCL_STD_V28;
					end
					`SCL_XCVR_V28: begin
						dataStdNext = `SCL_STD_V28;
						hsStdNext = `SCL_STD_V28;
					end
					`SCL_XCVR_HIZ: begin
						dataStdNext = `SCL_STD_HIZ;
						hsStdNext = `SCL_STD_HIZ;
					end
					default: begin
						dataStdNext = `SCL_STD_V11;
						hsStdNext = `SCL_STD_V11;
					end
				endcase
			end

			// Registered line-side outputs
			// Reset leaves the carrier pin an input and all lines high impedance,
			// so nothing drives the cable before software has set a mode
			always @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					multIn_q <= 1'b0;
					genIn_q <= 1'b0;
					rxClk_q <= 1'b0;
					txClk_q <= 1'b0;
					rts_q <= 1'b0;
					carrier_out_value_q <= 1'b0;
					cdOe_b_q <= 1'b1;
					fifoLim_q <= `SCL_FIFO_DEEP;
					dataStd_q <= `SCL_STD_HIZ;
					hsStd_q <= `SCL_STD_HIZ;
				end else begin
					multIn_q <= genSrc;
					genIn_q <= genClk;
					rxClk_q <= rxSrc ^ cfg[`SCL_B_RXINV];
					txClk_q <= txClkNow;
					rts_q <= rtsNext;
					carrier_out_value_q <= cfg[`SCL_B_CDVAL];
					cdOe_b_q <= ~cfg[`SCL_B_CARRIER_PIN_DIR];
					fifoLim_q <= cfg[`SCL_B_SHALLOW] ? `SCL_FIFO_SHALLOW : `SCL_FIFO_DEEP;
					dataStd_q <= dataStdNext;
					hsStd_q <= hsStdNext;
				end
			end

			// Carrier level seen by the core: own value when driving, pin otherwise
			// Toggling the driven value therefore also raises the change flag
			assign carrierLevel[c] = cfg[`SCL_B_CARRIER_PIN_DIR] ? cfg[`SCL_B_CDVAL] : carrierPinIn[c];

			scl_flag uFlag (
				.clk(clk),
				.rst_b(rst_b),
				.level(carrierLevel[c]),
				.clr(flagClr[c]),
				.flag(carrierFlag[c])
			);

			assign multInClk[c] = multIn_q;
			assign multiplierHold[c] = cfg[`SCL_B_HOLD];
			assign baudGenIn[c] = genIn_q;
			assign rxCoreClk[c] = rxClk_q;
			assign txCoreClk[c] = txClk_q;
			assign rtsPin[c] = rts_q;
			assign carrierPinOut[c] = carrier_out_value_q;
			assign carrierPinOe_b[c] = cdOe_b_q;
			assign txFifoLimit[c*5 +: 5] = fifoLim_q;
			assign rxBitOrderMsb[c] = cfg[`SCL_B_MSB];
			assign dataLineStd[c*2 +: 2] = dataStd_q;
			assign hsLineStd[c*2 +: 2] = hsStd_q;
		end
	endgenerate
endmodule // scl_line_config
`default_nettype wire

// ---- scl_line_config_regs.vh ----
// Offsets, field positions, codes and reset values of the line configuration bank.
// Assumes a 12-bit byte address on the register port and 32-bit register words.
`ifndef SCL_LINE_CONFIG_REGS_VH
`define SCL_LINE_CONFIG_REGS_VH
`define SCL_OFF_CH0 12'h15C
`define SCL_OFF_CH1 12'h1DC
`define SCL_OFF_CH2 12'h25C
`define SCL_OFF_CH3 12'h2DC
`define SCL_OFF_STAT 12'h300
`define SCL_RST_VAL 32'h0000_0007
`define SCL_WMASK_CH3 32'h003F_FFFF
`define SCL_WMASK_CHX 32'h003B_FFFF
`define SCL_B_SHALLOW 21
`define SCL_B_DIRRTS 20
`define SCL_B_MSB 19
`define SCL_B_DTR 18
`define SCL_B_CDVAL 17
`define SCL_B_CARRIER_PIN_DIR 16
`define SCL_B_HOLD 15
`define SCL_B_X4 14
`define SCL_B_RXINV 13
`define SCL_B_TXINV 12
`define SCL_F_RCS 11:10
`define SCL_F_TCS 9:7
`define SCL_F_BCS 6:4
`define SCL_B_TX_CLK_ON_RTS_PIN 3
`define SCL_F_XCVR 2:0
`define SCL_F_STLVL 3:0
`define SCL_F_STFLG 7:4
`define SCL_RCS_BRG 2'h0
`define SCL_RCS_PIN 2'h1
`define SCL_RCS_DIGITAL_PLL 2'h2
`define SCL_TCS_BRG 3'h0
`define SCL_TCS_RXPIN 3'h1
`define SCL_TCS_TXPIN 3'h2
`define SCL_TCS_DIGITAL_PLL 3'h3
`define SCL_TCS_DIV16 3'h4
`define SCL_BCS_OSC1 3'h0
`define SCL_BCS_OSC2 3'h1
`define SCL_BCS_OSC3 3'h2
`define SCL_BCS_RXPIN 3'h3
`define SCL_BCS_TXPIN 3'h4
`define SCL_XCVR_V35 3'h4
`define SCL_XCVR_V28 3'h6
`define SCL_XCVR_HIZ 3'h7
`define SCL_STD_V11 2'h0
`define SCL_STD_V35 2'h1
`define SCL_STD_V28 2'h2
`define SCL_STD_HIZ 2'h3
`define SCL_FIFO_DEEP 5'h12
`define SCL_FIFO_SHALLOW 5'h04
`define SCL_DIV_LAST 3'h7
`endif

// ---- scl_flag.v ----
// Sticky change flag on a level, cleared by a strobe; a change beats the clear.
// Assumes the level is synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module scl_flag (
	input wire clk,
	input wire rst_b,
	input wire level,
	input wire clr,
	output wire flag
);
	reg prev_q;
	reg armed_q;
	reg flag_q;
	wire change;

	// The first cycle after reset only learns the level, so no false edge
	assign change = armed_q && (level != prev_q);
	assign flag = flag_q;

	// Edge memory and sticky flag
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prev_q <= 1'b0;
			armed_q <= 1'b0;
			flag_q <= 1'b0;
		end else begin
			prev_q <= level;
			armed_q <= 1'b1;
			flag_q <= change | (flag_q & ~clr);
		end
	end
endmodule // scl_flag
`default_nettype wire

// ---- scl_div16.v ----
// Divides a sampled clock level by sixteen, counting its rising edges.
// Assumes the source is far slower than clk and synchronous to it.
`timescale 1ns/1ps
`default_nettype none
`include "scl_line_config_regs.vh"
module scl_div16 (
	input wire clk,
	input wire rst_b,
	input wire src,
	output wire divOut
);
	reg prev_q;
	reg [2:0] cnt_q;
	reg out_q;
	wire rise;

	assign rise = src & ~prev_q;
	assign divOut = out_q;

	// Toggle every eighth rising edge: one output period per sixteen
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prev_q <= 1'b0;
			cnt_q <= 3'h0;
			out_q <= 1'b0;
		end else begin
			prev_q <= src;
			if (rise) begin
				cnt_q <= cnt_q + 3'h1;
				if (cnt_q == `SCL_DIV_LAST) begin
					out_q <= ~out_q;
				end
			end
		end
	end
endmodule // scl_div16
`default_nettype wire

// ---- scl_line_config_assertions.sv ----
// Port checker for the line configuration bank, bound to its top module.
// Assumes one clock domain and the register offsets of the shared header.
`timescale 1ns/1ps
`default_nettype none
`include "scl_line_config_regs.vh"
module scl_line_config_assertions (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [11:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [31:0] regRdData,
	input wire logic osc1Clk,
	input wire logic [3:0] rxClkPin,
	input wire logic [3:0] txClkPin,
	input wire logic [3:0] multInClk,
	input wire logic [3:0] multOutClk,
	input wire logic [3:0] forcedRtsBit,
	input wire logic [3:0] multiplierHold,
	input wire logic [3:0] baudGenIn,
	input wire logic [3:0] rxCoreClk,
	input wire logic [3:0] txCoreClk,
	input wire logic [3:0] rtsPin,
	input wire logic [3:0] carrierPinOut,
	input wire logic [3:0] carrierPinOe_b,
	input wire logic [19:0] txFifoLimit,
	input wire logic [7:0] dataLineStd,
	input wire logic [7:0] hsLineStd,
	input wire logic terminalReadyCh3
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	logic [31:0] lineCfg_q;
	// Mirror of the channel 0 word
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b) lineCfg_q <= `SCL_RST_VAL;
		else if (regWr && regAddr == `SCL_OFF_CH0) lineCfg_q <= regWrData;
	a_rd_idle_zero: assert property (!$past(regRd) |-> regRdData == 32'h0)
		else $error("read data not zero outside a read");
	a_hold_follows: assert property (regWr && regAddr == `SCL_OFF_CH0 |=>
		multiplierHold[0] == $past(regWrData[15])) else $error("hold wrong");
	a_fifo_depth: assert property (regWr && regAddr == `SCL_OFF_CH1 |=> ##1
		txFifoLimit[9:5] == ($past(regWrData[21], 2) ? `SCL_FIFO_SHALLOW : `SCL_FIFO_DEEP))
		else $error("fifo limit wrong");
	a_carrier_drive: assert property (regWr && regAddr == `SCL_OFF_CH2 |=> ##1
		carrierPinOe_b[2] == !$past(regWrData[16], 2) &&
		carrierPinOut[2] == $past(regWrData[17], 2)) else $error("carrier pin wrong");
	a_dtr_ch3: assert property (regWr && regAddr == `SCL_OFF_CH3 |=>
		terminalReadyCh3 == $past(regWrData[18])) else $error("terminal ready wrong");
	a_v35_split: assert property (regWr && regAddr == `SCL_OFF_CH0 &&
		regWrData[2:0] == `SCL_XCVR_V35 |=> ##1 dataLineStd[1:0] == `SCL_STD_V35 &&
		hsLineStd[1:0] == `SCL_STD_V28) else $error("line standard wrong");
	a_reset_hiz: assert property (!$past(rst_b) |->
		dataLineStd == 8'hFF && hsLineStd == 8'hFF) else $error("lines not idle");
	a_rx_pin_inv: assert property ($past(lineCfg_q[11:10]) == `SCL_RCS_PIN |->
		rxCoreClk[0] == ($past(rxClkPin[0]) ^ $past(lineCfg_q[13])))
		else $error("rx clock wrong");
	a_rts_direct: assert property ($past(lineCfg_q[20]) && !$past(lineCfg_q[3]) |->
		rtsPin[0] == $past(forcedRtsBit[0])) else $error("direct rts wrong");
	a_rts_txclk: assert property ($past(lineCfg_q[3]) |->
		rtsPin[0] == txCoreClk[0]) else $error("rts not tx clock");
	a_quad_source: assert property ($past(lineCfg_q[14]) |->
		baudGenIn[0] == $past(multOutClk[0])) else $error("multiplier path wrong");
	a_tx_pin_inv: assert property ($past(lineCfg_q[9:7]) == `SCL_TCS_TXPIN |->
		txCoreClk[0] == ($past(txClkPin[0]) ^ $past(lineCfg_q[12])))
		else $error("tx clock wrong");
	a_mult_input: assert property ($past(lineCfg_q[6:4]) == `SCL_BCS_OSC1 |->
		multInClk[0] == $past(osc1Clk)) else $error("multiplier input wrong");
endmodule // scl_line_config_assertions
bind scl_line_config scl_line_config_assertions i_chk (.clk, .rst_b, .regAddr,
	.regWrData, .regWr, .regRd, .regRdData, .osc1Clk, .rxClkPin, .txClkPin,
	.multInClk, .multOutClk, .forcedRtsBit,
	.multiplierHold, .baudGenIn, .rxCoreClk, .txCoreClk, .rtsPin, .carrierPinOut,
	.carrierPinOe_b, .txFifoLimit, .dataLineStd, .hsLineStd, .terminalReadyCh3);
`default_nettype wire

// ---- scl_far_side.sv ----
// Far side model: oscillators, remote clocks and the carrier pin wire.
// Assumes clock levels slow against clk; the remote carrier level comes in.
`timescale 1ns/1ps
`default_nettype none
module scl_far_side (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [3:0] cdRemote,
	input wire logic [3:0] carrierPinOut,
	input wire logic [3:0] carrierPinOe_b,
	output logic osc1Clk,
	output logic osc2Clk,
	output logic osc3Clk,
	output logic [3:0] rxClkPin,
	output logic [3:0] txClkPin,
	output logic [3:0] baudGenOut,
	output logic [3:0] pllClk,
	output logic [3:0] multOutClk,
	output logic [3:0] carrierPinIn
);
	logic [5:0] cnt_q;
	// Free-running divider; its bits set the source rates, and several sources share a rate
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b) cnt_q <= 6'h00;
		else cnt_q <= cnt_q + 6'h01;
	// Clock levels and the resolved carrier wire (device drives when enable low)
	assign {osc3Clk, osc2Clk, osc1Clk} = cnt_q[2:0];
	assign rxClkPin = {4{cnt_q[2]}} ^ 4'h5;
	assign txClkPin = {4{cnt_q[3]}};
	assign baudGenOut = {4{cnt_q[1]}};
	assign pllClk = {4{cnt_q[4]}};
	assign multOutClk = {4{cnt_q[0]}};
	assign carrierPinIn = (carrierPinOe_b & cdRemote) | (~carrierPinOe_b & carrierPinOut);
endmodule // scl_far_side
`default_nettype wire

// ---- scl_line_config_tb_top.sv ----
// Self-checking bench for the line configuration bank.
// Assumes the far side model supplies all clock levels and the carrier wire.
`timescale 1ns/1ps
`default_nettype none
`include "scl_line_config_regs.vh"
module scl_line_config_tb_top;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [11:0] regAddr = 12'h000;
	logic [31:0] regWrData = 32'h0;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic [3:0] forcedRts = 4'h1;
	logic [3:0] cdRemote = 4'h0;
	logic [11:0] offs [4] = '{`SCL_OFF_CH0, `SCL_OFF_CH1, `SCL_OFF_CH2, `SCL_OFF_CH3};
	wire [31:0] rdData;
	wire o1, o2, o3, terminal_ready_ch3;
	wire [3:0] rxp, txp, bgo, pll, mox, cdIn, hold, rts, carrier_out_value, cdOe_b, msb;
	wire [19:0] fifoLim;
	wire [7:0] dStd, hStd;
	integer n_mismatch = 0;
	integer n_compared = 0;
	// 40 MHz clock
	always #12.5 clk = ~clk;
	scl_far_side i_far (.clk, .rst_b, .cdRemote, .carrierPinOut(carrier_out_value),
		.carrierPinOe_b(cdOe_b), .osc1Clk(o1), .osc2Clk(o2), .osc3Clk(o3), .rxClkPin(rxp),
		.txClkPin(txp), .baudGenOut(bgo), .pllClk(pll), .multOutClk(mox), .carrierPinIn(cdIn));
	scl_line_config i_dut (.clk, .rst_b, .regAddr, .regWrData, .regWr, .regRd,
		.regRdData(rdData), .osc1Clk(o1), .osc2Clk(o2), .osc3Clk(o3), .rxClkPin(rxp),
		.txClkPin(txp), .baudGenOut(bgo), .pllRxClk(pll), .pllTxClk(~pll), .multOutClk(mox),
		.coreRts(4'h0), .forcedRtsBit(forcedRts), .carrierPinIn(cdIn), .multInClk(),
		.multiplierHold(hold), .baudGenIn(), .rxCoreClk(), .txCoreClk(), .rtsPin(rts),
		.carrierPinOut(carrier_out_value), .carrierPinOe_b(cdOe_b), .txFifoLimit(fifoLim),
		.rxBitOrderMsb(msb), .dataLineStd(dStd), .hsLineStd(hStd), .terminalReadyCh3(terminal_ready_ch3));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %0h, expected %0h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWrData <= d;
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		@(negedge clk);
		chk(rdData, exp);
	endtask
	task automatic look(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	function automatic logic [3:0] stdOf(input logic [2:0] m);
		case (m)
			`SCL_XCVR_V35: stdOf = {`SCL_STD_V28, `SCL_STD_V35};
			`SCL_XCVR_V28: stdOf = {`SCL_STD_V28, `SCL_STD_V28};
			`SCL_XCVR_HIZ: stdOf = {`SCL_STD_HIZ, `SCL_STD_HIZ};
			default: stdOf = {`SCL_STD_V11, `SCL_STD_V11};
		endcase
	endfunction
	task automatic t_reset();
		for (int i = 0; i < 4; i++) rd(offs[i], `SCL_RST_VAL);
		rd(12'h100, 32'h0);
		chk(fifoLim, {4{`SCL_FIFO_DEEP}});
		chk(cdOe_b, 4'hF);
	endtask
	task automatic t_readback();
		for (int i = 0; i < 4; i++) begin
			wr(offs[i], 32'hFFFFFFFF);
			rd(offs[i], i == 3 ? `SCL_WMASK_CH3 : `SCL_WMASK_CHX);
		end
		look(2);
		chk(fifoLim, {4{`SCL_FIFO_SHALLOW}});
		chk({cdOe_b, carrier_out_value}, 8'h0F);
		chk({terminal_ready_ch3, msb, hold}, 9'h1FF);
		wr(`SCL_OFF_CH1, 32'h0);
		look(2);
		chk({fifoLim[9:5], cdOe_b[1]}, {`SCL_FIFO_DEEP, 1'b1});
	endtask
	task automatic t_status();
		wr(`SCL_OFF_CH0, 32'h0);
		look(3);
		wr(`SCL_OFF_STAT, 32'hF0);
		cdRemote <= 4'h1;
		look(3);
		rd(`SCL_OFF_STAT, 32'h1D);
		wr(`SCL_OFF_STAT, 32'h10);
		rd(`SCL_OFF_STAT, 32'h0D);
	endtask
	task automatic t_xcvr();
		for (int k = 0; k < 8; k++) begin
			wr(`SCL_OFF_CH3, 32'h000C0000 | k);
			look(2);
			chk({hStd[7:6], dStd[7:6]}, stdOf(k));
			chk({terminal_ready_ch3, msb[3]}, 2'h3);
		end
	endtask
	task automatic t_clocks();
		wr(`SCL_OFF_CH0, 32'h0010A504);
		look(8);
		chk({hold[0], rts[0]}, 2'h3);
		chk({hStd[1:0], dStd[1:0]}, stdOf(3'h4));
		@(posedge clk);
		forcedRts <= 4'h0;
		look(2);
		chk(rts[0], 1'b0);
		wr(`SCL_OFF_CH0, 32'h0000550E);
		look(16);
		chk(hold[0], 1'b0);
	endtask
	task automatic tally_and_finish();
		if (n_mismatch == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Reset, then the scenarios in order
	initial begin
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		t_reset();
		t_readback();
		t_status();
		t_xcvr();
		t_clocks();
		tally_and_finish();
	end
	// Watchdog well past the expected run length
	initial begin
		#100000;
		n_mismatch++;
		tally_and_finish();
	end
endmodule // scl_line_config_tb_top
`default_nettype wire
